// *** core/asb_pkg.sv ***
// Purpose: constants and types for the automatic serial buffer transfer block
// Assumes: APB slave, 32-bit data, pclk at 125 MHz
// Notes: Functional notes below
//
// Functional notes
// - Combined mode stores final received byte to buffer and raises done interrupt on the same clock.
// - Transmit-only run starts on start trigger with enable, auto, transmit set.
// - Transmit-only run raises done interrupt after the final byte shifts out.
// - Busy flag clears together with the completion interrupt.
// - Each completed byte short of the pointer increments the address counter, next byte then loaded.
// - A gap set by the byte interval setting follows each byte except the one that ends the run.
// - CPU buffer access in the load state delays the next byte load.
// - Serial output is low whenever busy is clear.
// - Repeat run starts on trigger with enable, auto, repeat, transmit set.
// - Repeat mode wraps counter to zero and resends without interrupt.
// - Units are 8 bits; output changes on falling serial clock.
// - Bit order select: 0 MSB first, 1 LSB first, both directions.
// - Stop request halts only after the current byte finishes.
// - On suspension busy clears after the eighth bit.
// - Start trigger after suspension resumes from the preserved position.
// - Low-power halt suspends; leaving it continues where stopped.
// - Bytes ascend from buffer base; pointer is count minus one; max 32.
// - Transfer continues until the counter equals the last-byte pointer.
// - Input sampled on rising clock; byte written to buffer on that same clock.
// - Clearing channel enable ends without interrupt; other endings interrupt.
package asb_pkg;
   localparam logic [11:0] ASB_MODE_OFS = 12'h000;
   localparam logic [11:0] ASB_STAT_OFS = 12'h004;
   localparam logic [11:0] ASB_TRIG_OFS = 12'h008;
   localparam logic [11:0] ASB_PTR_OFS = 12'h00C;
   localparam logic [11:0] ASB_GAP_OFS = 12'h010;
   localparam logic [11:0] ASB_CNT_OFS = 12'h014;
   localparam logic [11:0] ASB_BUF_OFS = 12'h100;
   localparam int ASB_DEPTH = 32;
   localparam int ASB_SYNC_RESET = 0;
   localparam logic [31:0] ASB_RESET_WORD = 32'h0000_0000;
   typedef struct packed {
      logic order;
      logic rep;
      logic rxe;
      logic txe;
      logic ate;
      logic en;
   } asb_mode_t;
   localparam asb_mode_t ASB_MODE_RST = '0;
   typedef enum logic [1:0] {
      ASB_IDLE = 2'b00,
      ASB_LOAD = 2'b01,
      ASB_SHIFT = 2'b10,
      ASB_GAP = 2'b11
   } asb_state_t;
endpackage

// *** core/asb_top.sv ***
// Purpose: automatic buffer transfer sequencer of a clocked three-wire channel
// Assumes: serial clock arrives on a pin, sampled by pclk; idle high
// Notes: buffer at offset 0x100, 32 words, low byte used
`timescale 1ns/100ps
module asb_top
   import asb_pkg::*;
#(
   parameter int DEPTH = ASB_DEPTH
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic serial_clock_pin,
   input wire logic serial_in_pin,
   output logic serial_out_pin,
   input wire logic low_power_halt,
   output logic transfer_done_irq,
   output logic transfer_busy_flag
);
   // Counters are five bits wide, so only a full 32-byte buffer is served
   if (DEPTH != 32) begin : g_depth_chk
      $error("DEPTH must be 32");
   end

   logic [7:0] buf_mem [DEPTH];
   asb_mode_t mode_ff;
   asb_state_t st_ff;
   logic [4:0] last_byte_pointer_ff;
   logic [4:0] buffer_address_counter_ff;
   logic [7:0] byte_interval_setting_ff;
   logic [7:0] gap_ff;
   logic [7:0] shift_data_register_ff;
   logic [2:0] bit_ff;
   logic stop_ff;
   logic [2:0] sck_ff;
   logic [1:0] sin_ff;
   logic [1:0] halt_ff;
   logic sck_fall;
   logic sck_rise;
   logic wr;
   logic rd;
   logic cpu_buf;
   logic start_req;
   logic byte_end;
   logic last_hit;
   logic fresh_ff;

   function automatic logic [7:0] asb_flip(input logic [7:0] b);
      for (int i = 0; i < 8; i++) asb_flip[i] = b[7 - i];
   endfunction

   // Sync pins; edges only from the second and third stages
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sck_ff <= 3'h7;
         sin_ff <= 2'h0;
         halt_ff <= 2'h0;
      end else begin
         sck_ff <= {sck_ff[1:0], serial_clock_pin};
         sin_ff <= {sin_ff[0], serial_in_pin};
         halt_ff <= {halt_ff[0], low_power_halt};
      end
   end
   assign sck_fall = sck_ff[2] & ~sck_ff[1];
   assign sck_rise = ~sck_ff[2] & sck_ff[1];

   assign wr = psel & penable & pwrite;
   assign rd = psel & ~penable & ~pwrite;
   assign cpu_buf = psel & (paddr[11:8] == ASB_BUF_OFS[11:8]);
   assign start_req = wr & (paddr == ASB_TRIG_OFS) & pwdata[0] & mode_ff.en
      & mode_ff.ate & mode_ff.txe;
   assign byte_end = st_ff == ASB_SHIFT && sck_rise && bit_ff == 3'h7;
   assign last_hit = buffer_address_counter_ff == last_byte_pointer_ff;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_ff <= ASB_MODE_RST;
         last_byte_pointer_ff <= 5'h00;
         byte_interval_setting_ff <= 8'h00;
      end else if (wr) begin
         if (paddr == ASB_MODE_OFS) mode_ff <= asb_mode_t'(pwdata[5:0]);
         if (paddr == ASB_PTR_OFS) last_byte_pointer_ff <= pwdata[4:0];
         if (paddr == ASB_GAP_OFS) byte_interval_setting_ff <= pwdata[7:0];
      end
   end

   // Stop request held until the byte in progress ends
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stop_ff <= 1'b0;
      end else if (st_ff == ASB_IDLE || !mode_ff.en) begin
         stop_ff <= 1'b0;
      end else if (wr && paddr == ASB_TRIG_OFS && pwdata[1]) begin
         stop_ff <= 1'b1;
      end
   end

   // Next start after a completed run begins at byte zero; a stop keeps the position
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fresh_ff <= 1'b1;
      end else if (byte_end && mode_ff.en) begin
         fresh_ff <= last_hit && !mode_ff.rep;
      end
   end

   // Sequencer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff <= ASB_IDLE;
         buffer_address_counter_ff <= 5'h00;
         shift_data_register_ff <= 8'h00;
         bit_ff <= 3'h0;
         gap_ff <= 8'h00;
         transfer_done_irq <= 1'b0;
         transfer_busy_flag <= 1'b0;
      end else begin
         transfer_done_irq <= 1'b0;
         if (!mode_ff.en) begin
            st_ff <= ASB_IDLE;
            transfer_busy_flag <= 1'b0;
            buffer_address_counter_ff <= 5'h00;
         end else begin
            unique case (st_ff)
               ASB_IDLE: begin
                  if (start_req) begin
                     st_ff <= ASB_LOAD;
                     transfer_busy_flag <= 1'b1;
                     if (fresh_ff) buffer_address_counter_ff <= 5'h00;
                  end
               end
               ASB_LOAD: begin
                  // Buffer port busy with CPU: wait
                  if (!cpu_buf && !halt_ff[1]) begin
                     shift_data_register_ff <= mode_ff.order ?
                        asb_flip(buf_mem[buffer_address_counter_ff])
                        : buf_mem[buffer_address_counter_ff];
                     bit_ff <= 3'h0;
                     st_ff <= ASB_SHIFT;
                  end
               end
               ASB_SHIFT: begin
                  if (sck_rise) begin
                     // Sample taken and stored on the rising edge
                     shift_data_register_ff <= {shift_data_register_ff[6:0], sin_ff[1]};
                     bit_ff <= bit_ff + 3'h1;
                  end
                  if (byte_end) begin
                     gap_ff <= byte_interval_setting_ff;
                     if (last_hit && !mode_ff.rep) begin
                        st_ff <= ASB_IDLE;
                        transfer_busy_flag <= 1'b0;
                        transfer_done_irq <= 1'b1;
                        // Counter left at the pointer so software can read how far it got
                     end else begin
                        buffer_address_counter_ff <= last_hit ? 5'h00
                           : buffer_address_counter_ff + 5'h01;
                        if (stop_ff) begin
                           st_ff <= ASB_IDLE;
                           transfer_busy_flag <= 1'b0;
                           transfer_done_irq <= 1'b1;
                        end else begin
                           st_ff <= ASB_GAP;
                        end
                     end
                  end
               end
               ASB_GAP: begin
                  if (gap_ff != 8'h00) gap_ff <= gap_ff - 8'h01;
                  else if (!halt_ff[1]) st_ff <= ASB_LOAD;
               end
            endcase
         end
      end
   end

   // Received byte to buffer; skipped when receive is off
   logic [4:0] wr_idx;
   logic [7:0] rx_byte;
   assign wr_idx = paddr[6:2];
   assign rx_byte = {shift_data_register_ff[6:0], sin_ff[1]};
   always_ff @(posedge pclk) begin
      if (byte_end && mode_ff.rxe) begin
         buf_mem[buffer_address_counter_ff] <= mode_ff.order ? asb_flip(rx_byte) : rx_byte;
      end else if (wr && cpu_buf) begin
         buf_mem[wr_idx] <= pwdata[7:0];
      end
   end

   // Output changes on falling serial clock edge; low in the cycle busy falls
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         serial_out_pin <= 1'b0;
      end else if (!transfer_busy_flag || !mode_ff.en || st_ff != ASB_SHIFT || byte_end) begin
         serial_out_pin <= 1'b0;
      end else if (sck_fall) begin
         serial_out_pin <= shift_data_register_ff[7];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= ASB_RESET_WORD;
      end else if (rd) begin
         unique case (1'b1)
            paddr == ASB_MODE_OFS: prdata <= {26'h0, mode_ff};
            paddr == ASB_STAT_OFS: prdata <= {31'h0, transfer_busy_flag};
            paddr == ASB_PTR_OFS: prdata <= {27'h0, last_byte_pointer_ff};
            paddr == ASB_GAP_OFS: prdata <= {24'h0, byte_interval_setting_ff};
            paddr == ASB_CNT_OFS: prdata <= {27'h0, buffer_address_counter_ff};
            cpu_buf: prdata <= {24'h0, buf_mem[wr_idx]};
            default: prdata <= ASB_RESET_WORD;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel & ~penable;
         pslverr <= 1'b0;
      end
   end

   property p_idle_low;
      @(posedge pclk) disable iff (!presetn)
      !transfer_busy_flag |-> !serial_out_pin;
   endproperty
   a_idle_low: assert property (p_idle_low) else $error("output not low");

   property p_done_busy;
      @(posedge pclk) disable iff (!presetn)
      transfer_done_irq |-> !transfer_busy_flag;
   endproperty
   a_done_busy: assert property (p_done_busy) else $error("busy with done");

   property p_start;
      @(posedge pclk) disable iff (!presetn)
      (st_ff == ASB_IDLE && start_req && mode_ff.en) |=> transfer_busy_flag;
   endproperty
   a_start: assert property (p_start) else $error("no start");

   property p_rep_noirq;
      @(posedge pclk) disable iff (!presetn)
      (byte_end && mode_ff.rep && !stop_ff && mode_ff.en) |=> !transfer_done_irq;
   endproperty
   a_rep_noirq: assert property (p_rep_noirq) else $error("repeat irq");

   property p_en_off;
      @(posedge pclk) disable iff (!presetn)
      !mode_ff.en |=> !transfer_done_irq && !transfer_busy_flag;
   endproperty
   a_en_off: assert property (p_en_off) else $error("enable off irq");

   property p_stop;
      @(posedge pclk) disable iff (!presetn)
      (byte_end && stop_ff && mode_ff.en) |=> st_ff == ASB_IDLE;
   endproperty
   a_stop: assert property (p_stop) else $error("stop missed");

   property p_gap;
      @(posedge pclk) disable iff (!presetn)
      (st_ff == ASB_GAP && gap_ff != 8'h00 && mode_ff.en) |=> st_ff == ASB_GAP;
   endproperty
   a_gap: assert property (p_gap) else $error("gap short");

   property p_incr;
      @(posedge pclk) disable iff (!presetn)
      (byte_end && !last_hit && mode_ff.en) |=>
         buffer_address_counter_ff == $past(buffer_address_counter_ff) + 5'h01;
   endproperty
   a_incr: assert property (p_incr) else $error("no increment");

   property p_done_hold;
      @(posedge pclk) disable iff (!presetn)
      (byte_end && last_hit && !mode_ff.rep && mode_ff.en) |=>
         buffer_address_counter_ff == $past(buffer_address_counter_ff);
   endproperty
   a_done_hold: assert property (p_done_hold) else $error("counter moved at end");

   property p_load_stall;
      @(posedge pclk) disable iff (!presetn)
      (st_ff == ASB_LOAD && cpu_buf && mode_ff.en) |=> st_ff == ASB_LOAD;
   endproperty
   a_load_stall: assert property (p_load_stall) else $error("load during bus access");

   c_done: cover property (@(posedge pclk) transfer_done_irq);
   c_wrap: cover property (@(posedge pclk) byte_end && last_hit && mode_ff.rep);
   c_stop: cover property (@(posedge pclk) byte_end && stop_ff);
   c_rx_store: cover property (@(posedge pclk) byte_end && mode_ff.rxe);
endmodule

// *** test/asb_peer.sv ***
// Purpose: serial peripheral model that drives the link clock
// Assumes: 125 ns link clock, idle high, runs only inside frames
// Notes: frame() swaps one byte, bits kept in order of arrival
`timescale 1ns/100ps
module asb_peer (
   input wire logic serial_out_pin,
   output logic serial_clock_pin,
   output logic serial_in_pin
);
   initial begin
      serial_clock_pin = 1'b1;
      serial_in_pin = 1'b0;
   end
   task automatic frame(input logic [7:0] d, output logic [7:0] q);
      for (int i = 7; i >= 0; i--) begin
         serial_clock_pin = 1'b0;
         #10 serial_in_pin = d[i];
         #52.5 serial_clock_pin = 1'b1;
         q[i] = serial_out_pin;
         #62.5;
      end
      // Released line must not keep the last bit
      serial_in_pin = ~serial_in_pin;
   endtask
endmodule

// *** test/asb_top_tb_top.sv ***
// Purpose: self-checking bench for the buffer transfer sequencer
// Assumes: gap setting counts pclk cycles; frames spaced well apart
// Notes: buffer model in mem, compared at every serial byte
`timescale 1ns/100ps
module asb_top_tb_top;
   import asb_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, halt;
   logic sck, sin, sout, irq, busy, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [7:0] mem [0:31];
   int failures, compares, irqs, cyc, i0;
   asb_top #(.DEPTH(ASB_DEPTH)) i_asb_top(.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .serial_clock_pin(sck), .serial_in_pin(sin),
      .serial_out_pin(sout), .low_power_halt(halt), .transfer_done_irq(irq),
      .transfer_busy_flag(busy));
   asb_peer i_asb_peer(.serial_out_pin(sout), .serial_clock_pin(sck), .serial_in_pin(sin));
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   task finish_test();
      $display("failures %0d compares %0d", failures, compares);
      if (failures == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   always @(posedge pclk) begin
      cyc++;
      if (irq === 1'b1) irqs++;
      if (cyc == 60000) begin
         failures++;
         finish_test();
      end
   end
   task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: %s got %0h exp %0h", $time, m, got, exp);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      // Only the bench timeout ends a wait
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   function automatic logic [7:0] rev(input logic [7:0] b);
      for (int i = 0; i < 8; i++) rev[i] = b[7-i];
   endfunction
   task load(input int n, input logic [31:0] mode);
      for (int i = 0; i < n; i++) begin
         mem[i] = 8'($urandom);
         apb(1'b1, ASB_BUF_OFS + 12'(4*i), {24'h0, mem[i]});
      end
      apb(1'b1, ASB_PTR_OFS, 32'(n-1));
      apb(1'b1, ASB_GAP_OFS, 32'h4);
      apb(1'b0, ASB_STAT_OFS, 32'h0);
      chk(rd, 32'h0, "status busy");
      apb(1'b1, ASB_MODE_OFS, mode);
      apb(1'b0, ASB_PTR_OFS, 32'h0);
      chk(rd, 32'(n-1), "pointer");
      apb(1'b0, ASB_MODE_OFS, 32'h0);
      chk(rd, mode, "mode");
      i0 = irqs;
   endtask
   task trig(input logic [31:0] v);
      apb(1'b1, ASB_TRIG_OFS, v);
      repeat (10) @(posedge pclk);
   endtask
   task frames(input int st, input int cnt, input int len, input logic ord, input logic rx);
      logic [7:0] pin, got;
      int idx;
      for (int k = 0; k < cnt; k++) begin
         idx = (st + k) % len;
         pin = 8'($urandom);
         chk({31'h0, busy}, 32'h1, "busy run");
         i_asb_peer.frame(pin, got);
         chk({24'h0, got}, {24'h0, ord ? rev(mem[idx]) : mem[idx]}, "byte");
         if (rx) mem[idx] = ord ? rev(pin) : pin;
         apb(1'b0, ASB_BUF_OFS + 12'(4*idx), 32'h0);
         chk(rd, {24'h0, mem[idx]}, "buffer");
         repeat (60) @(posedge pclk);
      end
   endtask
   task idle_chk(input int ni);
      chk({31'h0, busy}, 32'h0, "busy");
      chk({31'h0, sout}, 32'h0, "out");
      chk(32'(irqs - i0), 32'(ni), "irq count");
   endtask
   initial begin
      {presetn, psel, penable, pwrite, halt, paddr, pwdata} = '0;
      void'($urandom(65404));
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, 12'hFFC, 32'h0);
      chk(rd, 32'h0, "unmapped");
      chk({31'h0, err}, 32'h0, "slverr");
      load(3, 32'h03);
      trig(32'h1);
      idle_chk(0);
      load(3, 32'h0F);
      trig(32'h1);
      frames(0, 1, 3, 1'b0, 1'b1);
      chk(32'(irqs - i0), 32'h0, "early irq");
      halt <= 1'b1;
      repeat (100) @(posedge pclk);
      halt <= 1'b0;
      frames(1, 2, 3, 1'b0, 1'b1);
      idle_chk(1);
      apb(1'b0, ASB_CNT_OFS, 32'h0);
      chk(rd, 32'h2, "counter");
      load(2, 32'h27);
      trig(32'h1);
      frames(0, 2, 2, 1'b1, 1'b0);
      idle_chk(1);
      load(2, 32'h17);
      trig(32'h1);
      frames(0, 5, 2, 1'b0, 1'b0);
      apb(1'b1, ASB_MODE_OFS, 32'h0);
      repeat (10) @(posedge pclk);
      idle_chk(0);
      load(3, 32'h07);
      trig(32'h1);
      apb(1'b1, ASB_TRIG_OFS, 32'h2);
      frames(0, 1, 3, 1'b0, 1'b0);
      idle_chk(1);
      apb(1'b0, ASB_CNT_OFS, 32'h0);
      chk(rd, 32'h1, "kept position");
      trig(32'h1);
      frames(1, 2, 3, 1'b0, 1'b0);
      idle_chk(2);
      finish_test();
   end
endmodule
